/* File: mcc_pkg.sv */
// Package for the main clock and time-base unit: register map, fields, timing
package mcc_pkg;
  // Register map (offset 0x2d is not word aligned: both kept as indices)
  localparam logic [7:0] MCC_IDX_CTRL_STATUS = 8'h2c;
  localparam logic [7:0] MCC_IDX_TONE = 8'h2d;
  localparam logic [9:0] MCC_ADDR_CTRL_STATUS = {MCC_IDX_CTRL_STATUS, 2'b00};
  localparam logic [9:0] MCC_ADDR_TONE = {MCC_IDX_TONE, 2'b00};
  localparam logic [7:0] MCC_CSR_RESET = 8'h00;
  localparam logic [7:0] MCC_TONE_RESET = 8'h00;
  // Field positions in the control/status register
  localparam int MCC_BIT_CLK_OUT_EN = 7;
  localparam int MCC_BIT_RATIO_HI = 6;
  localparam int MCC_BIT_RATIO_LO = 5;
  localparam int MCC_BIT_SLOW_SEL = 4;
  localparam int MCC_BIT_TB_HI = 3;
  localparam int MCC_BIT_TB_LO = 2;
  localparam int MCC_BIT_IRQ_EN = 1;
  localparam int MCC_BIT_FLAG = 0;
  // Time-base periods in oscillator cycles
  localparam logic [17:0] MCC_TB_PERIOD0 = 18'd16000;
  localparam logic [17:0] MCC_TB_PERIOD1 = 18'd32000;
  localparam logic [17:0] MCC_TB_PERIOD2 = 18'd80000;
  localparam logic [17:0] MCC_TB_PERIOD3 = 18'd200000;
  // Half periods of the tones (8 MHz: 2000, 4000, 8000 give ~2k, 1k, 500 Hz)
  localparam logic [12:0] MCC_TONE_HALF1 = 13'd2000;
  localparam logic [12:0] MCC_TONE_HALF2 = 13'd4000;
  localparam logic [12:0] MCC_TONE_HALF3 = 13'd8000;

  typedef enum logic [1:0] {
    MCC_PM_RUN,
    MCC_PM_WAIT,
    MCC_PM_ACTIVE_HALT,
    MCC_PM_HALT
  } mcc_pmode_t;

  typedef struct packed {
    logic [7:0] csr;
    logic [1:0] tone_sel;
    logic [1:0] tb_active;
    logic [17:0] tb_cnt;
    logic [3:0] pre_cnt;
    logic cpu_clk_en;
    logic [12:0] tone_cnt;
    logic tone_lvl;
    logic clk_out_lvl;
    logic clk_out_drive;
    logic tone_drive;
    logic tb_irq;
    logic wake;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } mcc_state_t;
endpackage

/* File: mcc_main_clock_timebase_unit.sv */
// Main clock controller with prescaler, clock-out, time base and tone output
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module mcc_main_clock_timebase_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_req,
  input wire logic wait_req,
  input wire logic wake_other,
  output logic cpu_clk_en,
  output logic clk_out_port_pin,
  output logic clk_out_oe_n,
  output logic tone_port_pin,
  output logic tone_oe_n,
  output logic timebase_irq,
  output logic wake_req,
  output logic [1:0] power_mode
);
  import mcc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mcc_state_t st_r;
  mcc_state_t st_nxt;
  mcc_pmode_t pm_r;
  mcc_pmode_t pm_nxt;
  logic [2:0] ctl_meta_r;
  logic [2:0] ctl_sync_r;

  // Power-mode requests come from outside this clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_meta_r <= 3'h0;
      ctl_sync_r <= 3'h0;
    end else begin
      ctl_meta_r <= {halt_req, wait_req, wake_other};
      ctl_sync_r <= ctl_meta_r;
    end
  end

  logic halt_s;
  logic wait_s;
  logic wake_s;
  assign halt_s = ctl_sync_r[2];
  assign wait_s = ctl_sync_r[1];
  assign wake_s = ctl_sync_r[0];

  function automatic logic [17:0] tb_period(input logic [1:0] sel);
    case (sel)
      2'h0: tb_period = MCC_TB_PERIOD0;
      2'h1: tb_period = MCC_TB_PERIOD1;
      2'h2: tb_period = MCC_TB_PERIOD2;
      default: tb_period = MCC_TB_PERIOD3;
    endcase
  endfunction

  function automatic logic [12:0] tone_half(input logic [1:0] sel);
    case (sel)
      2'h1: tone_half = MCC_TONE_HALF1;
      2'h2: tone_half = MCC_TONE_HALF2;
      default: tone_half = MCC_TONE_HALF3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic regs_live;
  logic tb_run;
  logic tb_end;
  logic tb_event;
  logic rd_csr;
  logic [3:0] pre_div;

  always_comb begin
    st_nxt = st_r;
    pm_nxt = pm_r;
    // Bus reads and writes act only in run and wait; both halt flavours ignore them
    regs_live = (pm_r == MCC_PM_RUN) || (pm_r == MCC_PM_WAIT);
    tb_run = (pm_r != MCC_PM_HALT);
    setup = psel && !penable;
    rd_csr = 1'b0;
    tb_end = tb_run && (st_r.tb_cnt >= tb_period(st_r.tb_active) - 18'd1);
    tb_event = tb_end;
    pre_div = 4'h0;

    // APB: no wait state, answer in the first access cycle after setup
    access = psel && penable && st_r.pready;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (setup) begin
      // Frozen in halt: still answer so the bus never hangs, reads give 0
      st_nxt.pready = 1'b1;
      st_nxt.prdata = 32'h0;
      if (paddr[11:0] == {2'b00, MCC_ADDR_CTRL_STATUS}) begin
        if (!pwrite && regs_live) begin
          st_nxt.prdata = {24'h0, st_r.csr};
        end
      end else if (paddr[11:0] == {2'b00, MCC_ADDR_TONE}) begin
        if (!pwrite && regs_live) begin
          st_nxt.prdata = {30'h0, st_r.tone_sel};
        end
      end else begin
        st_nxt.pslverr = 1'b1;
      end
    end
    // Effects land at the edge that completes the transfer, not at setup
    if (access && regs_live && !st_r.pslverr) begin
      if (paddr[11:0] == {2'b00, MCC_ADDR_CTRL_STATUS}) begin
        if (pwrite) begin
          // Flag bit is hardware owned; writes to it are ignored
          st_nxt.csr[7:1] = pwdata[7:1];
        end else begin
          // Clear only a flag that software actually saw, so no event is lost
          rd_csr = st_r.prdata[MCC_BIT_FLAG];
        end
      end else if (paddr[11:0] == {2'b00, MCC_ADDR_TONE}) begin
        if (pwrite) begin
          st_nxt.tone_sel = pwdata[1:0];
        end
      end
    end

    // Time base counter; selection latched only at period end
    if (tb_run) begin
      if (tb_end) begin
        st_nxt.tb_cnt = 18'h0;
        st_nxt.tb_active = st_nxt.csr[MCC_BIT_TB_HI:MCC_BIT_TB_LO];
      end else begin
        st_nxt.tb_cnt = st_r.tb_cnt + 18'd1;
      end
    end
    // Flag: set wins over clear-on-read
    if (rd_csr) begin
      st_nxt.csr[MCC_BIT_FLAG] = 1'b0;
    end
    if (tb_event) begin
      st_nxt.csr[MCC_BIT_FLAG] = 1'b1;
    end
    st_nxt.tb_irq = st_nxt.csr[MCC_BIT_FLAG] && st_nxt.csr[MCC_BIT_IRQ_EN];

    // CPU clock enable, in run mode only: every cycle in normal mode, 1 of 2^(n+1) in slow
    pre_div = 4'h1 << st_r.csr[MCC_BIT_RATIO_HI:MCC_BIT_RATIO_LO];
    if (!st_r.csr[MCC_BIT_SLOW_SEL]) begin
      st_nxt.pre_cnt = 4'h0;
      st_nxt.cpu_clk_en = (pm_r == MCC_PM_RUN);
    end else begin
      st_nxt.pre_cnt = (st_r.pre_cnt >= {pre_div[2:0], 1'b0} - 4'h1) ? 4'h0 : st_r.pre_cnt + 4'h1;
      st_nxt.cpu_clk_en = (pm_r == MCC_PM_RUN) && (st_r.pre_cnt == 4'h0);
    end

    // Clock-out: divided-by-two toggle of the osc clock, off in active-halt
    st_nxt.clk_out_drive = st_r.csr[MCC_BIT_CLK_OUT_EN] && (pm_r != MCC_PM_ACTIVE_HALT)
                           && (pm_r != MCC_PM_HALT);
    st_nxt.clk_out_lvl = st_nxt.clk_out_drive ? ~st_r.clk_out_lvl : 1'b0;

    // Tone generator divides the osc clock, runs in active-halt too
    if (st_r.tone_sel == 2'h0 || pm_r == MCC_PM_HALT) begin
      st_nxt.tone_cnt = 13'h0;
      st_nxt.tone_lvl = 1'b0;
      st_nxt.tone_drive = 1'b0;
    end else begin
      st_nxt.tone_drive = 1'b1;
      if (st_r.tone_cnt >= tone_half(st_r.tone_sel) - 13'd1) begin
        st_nxt.tone_cnt = 13'h0;
        st_nxt.tone_lvl = ~st_r.tone_lvl;
      end else begin
        st_nxt.tone_cnt = st_r.tone_cnt + 13'd1;
      end
    end

    // Power mode sequencing
    st_nxt.wake = 1'b0;
    case (pm_r)
      MCC_PM_RUN: begin
        if (halt_s) begin
          pm_nxt = st_r.csr[MCC_BIT_IRQ_EN] ? MCC_PM_ACTIVE_HALT : MCC_PM_HALT;
        end else if (wait_s) begin
          pm_nxt = MCC_PM_WAIT;
        end
      end
      MCC_PM_WAIT: begin
        if (st_nxt.tb_irq || wake_s) begin
          pm_nxt = MCC_PM_RUN;
          st_nxt.wake = 1'b1;
        end
      end
      MCC_PM_ACTIVE_HALT: begin
        if (st_nxt.tb_irq || wake_s) begin
          pm_nxt = MCC_PM_RUN;
          st_nxt.wake = 1'b1;
        end
      end
      default: begin
        // Only an interrupt able to leave halt gets us out
        if (wake_s) begin
          pm_nxt = MCC_PM_RUN;
          st_nxt.wake = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.csr <= MCC_CSR_RESET;
      st_r.tone_sel <= MCC_TONE_RESET[1:0];
      pm_r <= MCC_PM_RUN;
    end else begin
      st_r <= st_nxt;
      pm_r <= pm_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign cpu_clk_en = st_r.cpu_clk_en;
  assign clk_out_port_pin = st_r.clk_out_lvl;
  assign clk_out_oe_n = ~st_r.clk_out_drive;
  assign tone_port_pin = st_r.tone_lvl;
  assign tone_oe_n = ~st_r.tone_drive;
  assign timebase_irq = st_r.tb_irq;
  assign wake_req = st_r.wake;
  assign power_mode = pm_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_flag_set;
    @(posedge pclk) disable iff (!presetn) tb_event |=> st_r.csr[MCC_BIT_FLAG];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set at period end");

  property p_irq_gate;
    @(posedge pclk) disable iff (!presetn) timebase_irq |-> $past(st_nxt.csr[MCC_BIT_IRQ_EN]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

  property p_clkout_ah;
    @(posedge pclk) disable iff (!presetn) (pm_r == MCC_PM_ACTIVE_HALT) ##1 (pm_r == MCC_PM_ACTIVE_HALT)
      |-> clk_out_oe_n;
  endproperty
  a_clkout_ah: assert property (p_clkout_ah) else $error("clock-out driven in active-halt");

  property p_halt_sel;
    @(posedge pclk) disable iff (!presetn) (pm_r == MCC_PM_RUN && halt_s) |=>
      (pm_r == (st_r.csr[MCC_BIT_IRQ_EN] ? MCC_PM_ACTIVE_HALT : MCC_PM_HALT));
  endproperty
  a_halt_sel: assert property (p_halt_sel) else $error("wrong halt flavour");

  property p_halt_freeze;
    @(posedge pclk) disable iff (!presetn) (pm_r == MCC_PM_HALT && pm_nxt == MCC_PM_HALT)
      |=> $stable(st_r.tb_cnt) && $stable(st_r.csr);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("halt not frozen");

  property p_ah_count;
    @(posedge pclk) disable iff (!presetn) (pm_r == MCC_PM_ACTIVE_HALT && !tb_end) |=>
      st_r.tb_cnt == $past(st_r.tb_cnt) + 18'd1;
  endproperty
  a_ah_count: assert property (p_ah_count) else $error("counter stopped in active-halt");

  property p_no_halt_wake;
    @(posedge pclk) disable iff (!presetn) (pm_r == MCC_PM_HALT && !wake_s) |=> pm_r == MCC_PM_HALT;
  endproperty
  a_no_halt_wake: assert property (p_no_halt_wake) else $error("left halt without wake");

  property p_normal_clk;
    @(posedge pclk) disable iff (!presetn) (pm_r == MCC_PM_RUN && !st_r.csr[MCC_BIT_SLOW_SEL])
      ##1 (pm_r == MCC_PM_RUN) |-> cpu_clk_en;
  endproperty
  a_normal_clk: assert property (p_normal_clk) else $error("cpu clock gated in normal mode");

  property p_tone_off;
    @(posedge pclk) disable iff (!presetn) (st_r.tone_sel == 2'h0) |=> tone_oe_n && !tone_port_pin;
  endproperty
  a_tone_off: assert property (p_tone_off) else $error("tone driven when off");

  c_flag: cover property (@(posedge pclk) disable iff (!presetn) tb_event);
  c_ah_wake: cover property (@(posedge pclk) disable iff (!presetn)
    pm_r == MCC_PM_ACTIVE_HALT ##1 pm_r == MCC_PM_RUN);
  c_read_clear: cover property (@(posedge pclk) disable iff (!presetn) rd_csr && st_r.csr[MCC_BIT_FLAG]);
endmodule
`default_nettype wire

/* File: mcc_pin_probe.sv */
// Model of an external device listening on an alternate-function pin
`timescale 1ns/1ps
`default_nettype none
module mcc_pin_probe (
  input wire logic pclk,
  input wire logic pin,
  input wire logic oe_n,
  output logic [15:0] half_len
);
  logic line;
  logic last;
  logic [15:0] run;
  // A released pin is pulled up on the board, so it never shows a stale level
  assign line = oe_n ? 1'b1 : pin;
  initial begin
    half_len = 16'h0000;
    run = 16'h0000;
    last = 1'b1;
  end
  // Length of the last completed level, in clock cycles
  always @(posedge pclk) begin
    last <= line;
    if (line != last) begin
      half_len <= run;
      run <= 16'h0001;
    end else begin
      run <= run + 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* File: main_clock_ctrl_rtc_beeper_tb_top.sv */
// Self-checking testbench for the main clock and time-base unit
`timescale 1ns/1ps
`default_nettype none
module main_clock_ctrl_rtc_beeper_tb_top;
  import mcc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, halt_req, wait_req, wake_other;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic pready, pslverr, cpu_clk_en, clk_out_port_pin, clk_out_oe_n;
  logic tone_port_pin, tone_oe_n, timebase_irq, wake_req, err;
  logic [1:0] power_mode;
  logic [15:0] clk_half, tone_half;
  int mismatches, checked, t0, t1, n, w0;
  int cyc = 0;
  int wakes = 0;
  localparam logic [9:0] CSR = MCC_ADDR_CTRL_STATUS[9:0];
  localparam logic [9:0] TONE = MCC_ADDR_TONE[9:0];

  mcc_main_clock_timebase_unit i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .halt_req, .wait_req, .wake_other, .cpu_clk_en, .clk_out_port_pin,
    .clk_out_oe_n, .tone_port_pin, .tone_oe_n, .timebase_irq, .wake_req, .power_mode);
  mcc_pin_probe i_clk_probe (.pclk(pclk), .pin(clk_out_port_pin), .oe_n(clk_out_oe_n), .half_len(clk_half));
  mcc_pin_probe i_tone_probe (.pclk(pclk), .pin(tone_port_pin), .oe_n(tone_oe_n), .half_len(tone_half));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wake_req === 1'b1) begin
      wakes <= wakes + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("counts: %0d comparisons, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    mismatches++;
    $display("wrong value at %0t: no answer while %s", $time, what);
    end_of_test();
  endtask

  // Bus master: the request stays put until pready is sampled high
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {22'h0, a};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) hang("bus access");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [9:0] a, input logic [7:0] e, input string what);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e}, what);
  endtask

  task automatic count_en(output int c);
    c = 0;
    repeat (64) begin
      @(posedge pclk);
      if (cpu_clk_en === 1'b1) c++;
    end
  endtask

  task automatic wait_irq(output int t);
    int k;
    k = 0;
    while (timebase_irq !== 1'b1 && k < 40000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 40000) hang("time base");
    t = cyc;
  endtask

  task automatic wait_mode(input mcc_pmode_t m);
    int k;
    k = 0;
    while (power_mode !== m && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 20) hang("power mode");
  endtask

  initial begin
    {presetn, psel, penable, pwrite, halt_req, wait_req, wake_other} = 7'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    {mismatches, checked} = {32'h0, 32'h0};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk({30'h0, clk_out_oe_n, tone_oe_n}, 32'h3, "pins released");
    rdchk(CSR, MCC_CSR_RESET, "csr reset");
    rdchk(TONE, MCC_TONE_RESET, "tone reset");
    apb(1'b0, 10'h3fc, 8'h00);
    chk({31'h0, err}, 32'h1, "unmapped");
    $display("test registers done");
    // Ratio must be ignored while slow select is clear
    apb(1'b1, CSR, 8'h60);
    count_en(n);
    count_en(n);
    chk(n, 32'h40, "normal cpu clock");
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, CSR, {1'b0, c[1:0], 1'b1, 4'h0});
      count_en(n);
      count_en(n);
      chk(n, 32'h20 >> c, "slow cpu clock");
    end
    $display("test prescaler done");
    apb(1'b1, TONE, 8'h01);
    apb(1'b1, CSR, 8'h82);
    count_en(n);
    chk({16'h0, clk_half}, 32'h1, "clock out");
    wait_irq(t0);
    apb(1'b1, CSR, 8'h86);
    rdchk(CSR, 8'h87, "flag set");
    rdchk(CSR, 8'h86, "flag cleared");
    chk({16'h0, tone_half}, MCC_TONE_HALF1, "tone 1");
    apb(1'b1, TONE, 8'h02);
    wait_irq(t1);
    chk(t1 - t0, MCC_TB_PERIOD0, "old period kept");
    chk({16'h0, tone_half}, MCC_TONE_HALF2, "tone 2");
    apb(1'b1, TONE, 8'h03);
    rdchk(CSR, 8'h87, "flag again");
    $display("test time base done");
    halt_req <= 1'b1;
    wait_mode(MCC_PM_ACTIVE_HALT);
    halt_req <= 1'b0;
    w0 = wakes;
    @(posedge pclk);
    chk({31'h0, clk_out_oe_n}, 32'h1, "clock out stopped");
    apb(1'b1, CSR, 8'h00);
    rdchk(CSR, 8'h00, "frozen read");
    wait_irq(t0);
    chk(t0 - t1, MCC_TB_PERIOD1, "period in active halt");
    wait_mode(MCC_PM_RUN);
    @(posedge pclk);
    chk(wakes - w0, 32'h1, "wake pulse");
    chk({16'h0, tone_half}, MCC_TONE_HALF3, "tone 3");
    rdchk(CSR, 8'h87, "write ignored");
    $display("test active halt done");
    apb(1'b1, CSR, 8'h00);
    halt_req <= 1'b1;
    wait_mode(MCC_PM_HALT);
    halt_req <= 1'b0;
    count_en(n);
    chk(n, 32'h0, "cpu stopped in halt");
    chk({31'h0, tone_oe_n}, 32'h1, "tone off in halt");
    wake_other <= 1'b1;
    wait_mode(MCC_PM_RUN);
    wake_other <= 1'b0;
    rdchk(CSR, 8'h00, "kept over halt");
    apb(1'b1, CSR, 8'h82);
    wait_req <= 1'b1;
    wait_mode(MCC_PM_WAIT);
    wait_req <= 1'b0;
    count_en(n);
    chk({clk_half, 15'h0, clk_out_oe_n}, 32'h10000, "clock out in wait");
    wait_irq(t0);
    wait_mode(MCC_PM_RUN);
    $display("test wait done");
    end_of_test();
  end
endmodule
`default_nettype wire
